// *** rtl/port1_pkg.sv ***
// Shared constants and types for the first parallel port sequencer
package port1_pkg;
	// ====================================================
	// Widths
	localparam int BUS_W = 32;
	localparam int HALF_W = 16;
	localparam int PIN_W = 4;
	localparam int BUF_DEPTH = 2;
	localparam int PTR_W = 1;
	localparam int CNT_W = 2;
	// ====================================================
	// Pin positions inside the synchroniser word
	localparam int PIN_ADDR_SELECT_N = 0;
	localparam int PIN_TARGET_READY_N = 1;
	localparam int PIN_CSEL = 2;
	localparam int PIN_RD = 3;
	// ====================================================
	// Reset values and buffer full count
	localparam logic STROBE_IDLE_N = 1'b1;
	localparam logic OE_RESET = 1'b0;
	localparam logic [BUS_W-1:0] BUS_RESET = 32'h0000_0000;
	localparam logic [HALF_W-1:0] COMM_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_FULL = 2'h2;
	// ====================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DWRITE,
		ST_DWAIT,
		ST_LAST,
		ST_CLEAN,
		ST_TRI,
		ST_CIN_WR,
		ST_CIN_STB,
		ST_COUT_R1,
		ST_COUT_R2,
		ST_COUT_DV
	} seq_state_t;
endpackage : port1_pkg

// *** rtl/word_stream_if.sv ***
// Valid/ready word stream between buffer and sequencer
`timescale 1ns/1ns
`default_nettype none
interface word_stream_if;
	logic valid;
	logic ready;
	logic [port1_pkg::BUS_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Pins
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_state_t;
	sync_state_t s_ff;
	sync_state_t nxt_s;
	// ====================================================
	// Stages
	always_comb begin
		nxt_s.meta = async_in;
		nxt_s.stable = s_ff.meta;
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign sync_out = s_ff.stable;
endmodule : pin_sync
`default_nettype wire

// *** rtl/word_buffer.sv ***
// Two-entry valid/ready buffer for outgoing write data
`timescale 1ns/1ns
`default_nettype none
module word_buffer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Filling side
	input wire logic in_valid_in,
	input wire logic [port1_pkg::BUS_W-1:0] in_data_in,
	output logic in_ready_out,
	// Draining side
	word_stream_if.src out_if
);
	typedef struct packed {
		logic [port1_pkg::BUF_DEPTH-1:0][port1_pkg::BUS_W-1:0] mem;
		logic [port1_pkg::PTR_W-1:0] wp;
		logic [port1_pkg::PTR_W-1:0] rp;
		logic [port1_pkg::CNT_W-1:0] cnt;
		logic not_full;
	} buf_state_t;
	buf_state_t s_ff;
	buf_state_t nxt_s;
	logic push;
	logic pop;
	// ====================================================
	// Pointer and count update
	always_comb begin
		nxt_s = s_ff;
		push = in_valid_in && s_ff.not_full;
		pop = out_if.ready && (s_ff.cnt != '0);
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data_in;
			nxt_s.wp = s_ff.wp + 1'b1;
		end
		if (pop) begin
			nxt_s.rp = s_ff.rp + 1'b1;
		end
		nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
		nxt_s.not_full = (nxt_s.cnt != port1_pkg::CNT_FULL);
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0, not_full: 1'b1};
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign in_ready_out = s_ff.not_full;
	assign out_if.valid = (s_ff.cnt != '0);
	assign out_if.data = s_ff.mem[s_ff.rp];
endmodule : word_buffer
`default_nettype wire

// *** rtl/port1_dma_write_comm_io.sv ***
// First parallel port DMA burst-write and comm register sequencer
// Function
// - Select and target-ready both low: enter address, drive address, strobes high.
// - From address with select high, ready low, flag low: go to data write.
// - Data write drives valid data, initiator-ready low; repeats while select high, ready low.
// - Target-ready high in data write enters data wait; waits are optional.
// - Data wait raises initiator-ready; outside ignores bus data.
// - From data wait, ready low, select high, flag low: resume data write.
// - Last-transfer flag high in data state with ready low: go to last transfer.
// - Last transfer like data write with end-of-burst low; followed by cleanup while select stays high.
// - Select low, ready high: tri-state bus from any non-comm state, remember origin.
// - From tri-state, comm select high, direction low: comm in write, bus released.
// - Stay in comm in write while comm select high; drop it to strobe.
// - Comm in strobe captures bus into 32-bit register of two halves.
// - Tri-state with comm select and direction high: read 1, read 2, data valid.
// - Data valid drives comm register, repeats while comm select high.
// - Cleanup with select high, ready low: idle with bus released, wait there; ready low with flag low there goes to data write.
// - Tri-state from last transfer or cleanup, select high, ready low: write, don't-care.
`timescale 1ns/1ns
`default_nettype none
module port1_dma_write_comm_io (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Bus control pins
	input wire logic addr_select_n_in,
	input wire logic target_ready_pin_n_in,
	input wire logic comm_port_select_in,
	input wire logic port_read_dir_in,
	output logic initiator_ready_n_out,
	output logic end_of_burst_n_out,
	output logic queue_request_n_out,
	// Multiplexed bus
	input wire logic [port1_pkg::BUS_W-1:0] port_addr_data_bus_in,
	output logic [port1_pkg::BUS_W-1:0] port_addr_data_bus_out,
	output logic port_addr_data_bus_oe_out,
	// Core side
	input wire logic last_transfer_flag_in,
	input wire logic [port1_pkg::BUS_W-1:0] burst_addr_in,
	input wire logic wr_valid_in,
	input wire logic [port1_pkg::BUS_W-1:0] wr_data_in,
	output logic wr_ready_out,
	input wire logic comm_load_in,
	input wire logic [port1_pkg::BUS_W-1:0] comm_load_data_in,
	output logic [port1_pkg::BUS_W-1:0] comm_reg_out,
	output logic comm_written_out
);
	typedef struct packed {
		port1_pkg::seq_state_t st;
		port1_pkg::seq_state_t tri_from;
		logic dont_care;
		logic [port1_pkg::BUS_W-1:0] bus;
		logic oe;
		logic initiator_ready_n_n;
		logic end_n;
		logic qreq_n;
		logic [port1_pkg::HALF_W-1:0] comm_reg_high;
		logic [port1_pkg::HALF_W-1:0] comm_reg_low;
		logic written;
	} seq_t;
	seq_t s_ff;
	seq_t nxt_s;
	logic [port1_pkg::PIN_W-1:0] pins_sync;
	logic [port1_pkg::BUS_W-1:0] bus_sync;
	logic sel_n;
	logic target_ready_n_n;
	logic csel;
	logic rd;
	logic last_transfer_flag;
	logic pop;
	word_stream_if wq ();
	// ====================================================
	// Pin synchronisers and data buffer
	pin_sync #(.W(port1_pkg::PIN_W)) u_pin_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		// Select and ready pass inverted so that a reset synchroniser reads them deasserted
		.async_in({port_read_dir_in, comm_port_select_in, ~target_ready_pin_n_in, ~addr_select_n_in}),
		.sync_out(pins_sync)
	);
	pin_sync #(.W(port1_pkg::BUS_W)) u_bus_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.async_in(port_addr_data_bus_in),
		.sync_out(bus_sync)
	);
	word_buffer u_buf (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(wr_valid_in),
		.in_data_in(wr_data_in),
		.in_ready_out(wr_ready_out),
		.out_if(wq.src)
	);
	assign sel_n = !pins_sync[port1_pkg::PIN_ADDR_SELECT_N];
	assign target_ready_n_n = !pins_sync[port1_pkg::PIN_TARGET_READY_N];
	assign csel = pins_sync[port1_pkg::PIN_CSEL];
	assign rd = pins_sync[port1_pkg::PIN_RD];
	assign last_transfer_flag = last_transfer_flag_in;
	assign wq.ready = pop;
	// ====================================================
	// Next state
	function automatic port1_pkg::seq_state_t burst_step(input logic flag);
		burst_step = flag ? port1_pkg::ST_LAST : port1_pkg::ST_DWRITE;
	endfunction : burst_step
	always_comb begin
		nxt_s = s_ff;
		nxt_s.written = 1'b0;
		nxt_s.dont_care = 1'b0;
		pop = 1'b0;
		if (!sel_n && !target_ready_n_n) begin
			nxt_s.st = port1_pkg::ST_ADDR;
		end else if (!sel_n && target_ready_n_n) begin
			case (s_ff.st)
				port1_pkg::ST_TRI: begin
					if (csel && rd) begin
						nxt_s.st = port1_pkg::ST_COUT_R1;
					end else if (csel) begin
						nxt_s.st = port1_pkg::ST_CIN_WR;
					end
				end
				port1_pkg::ST_CIN_WR: begin
					if (csel && !rd) begin
						nxt_s.st = port1_pkg::ST_CIN_WR;
					end else if (!csel && !rd) begin
						nxt_s.st = port1_pkg::ST_CIN_STB;
					end else begin
						nxt_s.st = port1_pkg::ST_TRI;
					end
				end
				port1_pkg::ST_COUT_R1: begin
					nxt_s.st = (csel && rd) ? port1_pkg::ST_COUT_R2 : port1_pkg::ST_TRI;
				end
				port1_pkg::ST_COUT_R2: begin
					nxt_s.st = (csel && rd) ? port1_pkg::ST_COUT_DV : port1_pkg::ST_TRI;
				end
				port1_pkg::ST_COUT_DV: begin
					nxt_s.st = (csel && rd) ? port1_pkg::ST_COUT_DV : port1_pkg::ST_TRI;
				end
				default: begin
					nxt_s.st = port1_pkg::ST_TRI;
				end
			endcase
			if (nxt_s.st == port1_pkg::ST_TRI && s_ff.st != port1_pkg::ST_TRI) begin
				nxt_s.tri_from = s_ff.st;
			end
		end else if (!target_ready_n_n) begin
			case (s_ff.st)
				port1_pkg::ST_ADDR, port1_pkg::ST_DWRITE, port1_pkg::ST_DWAIT: begin
					nxt_s.st = burst_step(last_transfer_flag);
				end
				port1_pkg::ST_LAST: begin
					nxt_s.st = port1_pkg::ST_CLEAN;
				end
				port1_pkg::ST_CLEAN: begin
					nxt_s.st = port1_pkg::ST_IDLE;
				end
				port1_pkg::ST_IDLE: begin
					nxt_s.st = last_transfer_flag ? port1_pkg::ST_IDLE : port1_pkg::ST_DWRITE;
				end
				port1_pkg::ST_TRI: begin
					if (s_ff.tri_from == port1_pkg::ST_LAST || s_ff.tri_from == port1_pkg::ST_CLEAN) begin
						nxt_s.st = port1_pkg::ST_DWRITE;
						nxt_s.dont_care = 1'b1;
					end else if (s_ff.tri_from == port1_pkg::ST_ADDR || s_ff.tri_from == port1_pkg::ST_DWRITE ||
						s_ff.tri_from == port1_pkg::ST_DWAIT) begin
						nxt_s.st = burst_step(last_transfer_flag);
					end
				end
				default: begin
					nxt_s.st = s_ff.st;
				end
			endcase
		end else begin
			case (s_ff.st)
				port1_pkg::ST_LAST: begin
					nxt_s.st = port1_pkg::ST_CLEAN;
				end
				port1_pkg::ST_ADDR, port1_pkg::ST_DWRITE, port1_pkg::ST_DWAIT, port1_pkg::ST_CLEAN,
				port1_pkg::ST_TRI: begin
					nxt_s.st = port1_pkg::ST_DWAIT;
				end
				default: begin
					nxt_s.st = s_ff.st;
				end
			endcase
		end
		// ====================================================
		// Outputs for the state being entered
		nxt_s.oe = 1'b1;
		nxt_s.initiator_ready_n_n = port1_pkg::STROBE_IDLE_N;
		nxt_s.end_n = port1_pkg::STROBE_IDLE_N;
		case (nxt_s.st)
			port1_pkg::ST_ADDR: begin
				nxt_s.bus = burst_addr_in;
			end
			port1_pkg::ST_DWRITE, port1_pkg::ST_LAST: begin
				if (!nxt_s.dont_care) begin
					pop = 1'b1;
					nxt_s.bus = wq.data;
					nxt_s.initiator_ready_n_n = 1'b0;
				end
				if (nxt_s.st == port1_pkg::ST_LAST) begin
					nxt_s.end_n = 1'b0;
				end
			end
			port1_pkg::ST_DWAIT, port1_pkg::ST_CLEAN: begin
				nxt_s.initiator_ready_n_n = port1_pkg::STROBE_IDLE_N;
			end
			port1_pkg::ST_COUT_DV: begin
				nxt_s.bus = {s_ff.comm_reg_high, s_ff.comm_reg_low};
			end
			default: begin
				nxt_s.oe = port1_pkg::OE_RESET;
			end
		endcase
		// ====================================================
		// Host communication register
		if (s_ff.st == port1_pkg::ST_CIN_STB) begin
			{nxt_s.comm_reg_high, nxt_s.comm_reg_low} = bus_sync;
			nxt_s.written = 1'b1;
		end else if (comm_load_in) begin
			{nxt_s.comm_reg_high, nxt_s.comm_reg_low} = comm_load_data_in;
		end
		nxt_s.qreq_n = !wq.valid;
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			s_ff <= '{st: port1_pkg::ST_IDLE, tri_from: port1_pkg::ST_IDLE, dont_care: 1'b0,
				bus: port1_pkg::BUS_RESET, oe: port1_pkg::OE_RESET, initiator_ready_n_n: port1_pkg::STROBE_IDLE_N,
				end_n: port1_pkg::STROBE_IDLE_N, qreq_n: 1'b1, comm_reg_high: port1_pkg::COMM_RESET,
				comm_reg_low: port1_pkg::COMM_RESET, written: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign initiator_ready_n_out = s_ff.initiator_ready_n_n;
	assign end_of_burst_n_out = s_ff.end_n;
	assign queue_request_n_out = s_ff.qreq_n;
	assign port_addr_data_bus_out = s_ff.bus;
	assign port_addr_data_bus_oe_out = s_ff.oe;
	assign comm_reg_out = {s_ff.comm_reg_high, s_ff.comm_reg_low};
	assign comm_written_out = s_ff.written;
	// ====================================================
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	sequence cout_entry_s;
		(s_ff.st == port1_pkg::ST_TRI) && !sel_n && target_ready_n_n && csel && rd;
	endsequence
	sequence cout_walk_s;
		(s_ff.st == port1_pkg::ST_COUT_R1) ##1 (s_ff.st == port1_pkg::ST_COUT_R2);
	endsequence
	reset_idle_a: assert property (disable iff (1'b0) !reset_n_in |=> s_ff.st == port1_pkg::ST_IDLE && !s_ff.oe
		&& s_ff.initiator_ready_n_n && s_ff.end_n) else $error("reset did not release bus");
	address_entry_a: assert property (!sel_n && !target_ready_n_n |=> s_ff.st == port1_pkg::ST_ADDR && s_ff.oe
		&& s_ff.bus == $past(burst_addr_in) && s_ff.initiator_ready_n_n && s_ff.end_n) else $error("address state wrong");
	addr_to_write_a: assert property (s_ff.st == port1_pkg::ST_ADDR && sel_n && !target_ready_n_n && !last_transfer_flag
		|=> s_ff.st == port1_pkg::ST_DWRITE && !initiator_ready_n_out) else $error("no write after address");
	write_wait_a: assert property (s_ff.st == port1_pkg::ST_DWRITE && sel_n && target_ready_n_n
		|=> s_ff.st == port1_pkg::ST_DWAIT && initiator_ready_n_out) else $error("wait not entered");
	wait_resume_a: assert property (s_ff.st == port1_pkg::ST_DWAIT && sel_n && !target_ready_n_n && !last_transfer_flag
		|=> s_ff.st == port1_pkg::ST_DWRITE) else $error("write not resumed");
	last_cleanup_a: assert property (s_ff.st == port1_pkg::ST_LAST && sel_n
		|=> s_ff.st == port1_pkg::ST_CLEAN && end_of_burst_n_out) else $error("cleanup missing");
	last_end_a: assert property (s_ff.st == port1_pkg::ST_LAST |-> !end_of_burst_n_out && !initiator_ready_n_out)
		else $error("end of burst not low");
	tri_release_a: assert property (!sel_n && target_ready_n_n && !csel && !(s_ff.st == port1_pkg::ST_CIN_WR && !rd)
		|=> !port_addr_data_bus_oe_out
		&& s_ff.tri_from == $past(s_ff.st == port1_pkg::ST_TRI ? s_ff.tri_from : s_ff.st))
		else $error("tri-state not entered");
	comm_capture_a: assert property (s_ff.st == port1_pkg::ST_CIN_STB |=> comm_reg_out == $past(bus_sync)
		&& comm_written_out) else $error("comm register not captured");
	comm_read_a: assert property (cout_entry_s ##1 (!sel_n && target_ready_n_n && csel && rd)[*2] |-> ##0 1'b1 ##0
		(s_ff.st == port1_pkg::ST_COUT_R2) ##1 (s_ff.st == port1_pkg::ST_COUT_DV && port_addr_data_bus_oe_out))
		else $error("comm read walk wrong");
	comm_walk_a: assert property (cout_entry_s ##1 (!sel_n && target_ready_n_n && csel && rd) |-> cout_walk_s)
		else $error("comm read start wrong");
	cleanup_idle_a: assert property (s_ff.st == port1_pkg::ST_CLEAN && sel_n && !target_ready_n_n
		|=> s_ff.st == port1_pkg::ST_IDLE && !port_addr_data_bus_oe_out) else $error("idle not reached");
endmodule : port1_dma_write_comm_io
`default_nettype wire

// *** sim/port1_arbiter_model.sv ***
// Outside arbiter and peripheral model for the first port
`timescale 1ns/1ns
`default_nettype none
module port1_arbiter_model (
	// Clock
	input wire logic clk_in,
	// Device bus side
	input wire logic [port1_pkg::BUS_W-1:0] bus_from_dev_in,
	input wire logic bus_oe_in,
	// Pins towards device
	output var logic addr_select_n_out = 1'b1,
	output var logic target_ready_n_out = 1'b1,
	output var logic comm_port_select_out = 1'b0,
	output var logic port_read_dir_out = 1'b0,
	output logic [port1_pkg::BUS_W-1:0] bus_level_out
);
	logic ext_en_ff = 1'b0;
	logic [port1_pkg::BUS_W-1:0] ext_data_ff = 32'h0000_0000;
	logic [port1_pkg::BUS_W-1:0] last_ff = 32'h0000_0000;
	// ====================================================
	// Bus level, released bus toggles every cycle unless the peripheral drives it
	assign bus_level_out = bus_oe_in ? bus_from_dev_in : (ext_en_ff ? ext_data_ff : ~last_ff);
	always @(posedge clk_in) begin
		last_ff <= bus_level_out;
	end
	// ====================================================
	// Pin levels, changed only at an edge
	task automatic set_pins(input logic sel_n, input logic target_ready_n_n, input logic csel, input logic rd);
		@(posedge clk_in);
		addr_select_n_out <= sel_n;
		target_ready_n_out <= target_ready_n_n;
		comm_port_select_out <= csel;
		port_read_dir_out <= rd;
	endtask : set_pins
	// ====================================================
	// Peripheral drive of the bus
	task automatic drive_bus(input logic en, input logic [port1_pkg::BUS_W-1:0] d);
		@(posedge clk_in);
		ext_en_ff <= en;
		ext_data_ff <= d;
	endtask : drive_bus
endmodule : port1_arbiter_model
`default_nettype wire

// *** sim/port1_dma_write_comm_io_tb.sv ***
// Testbench for the first port sequencer
`timescale 1ns/1ns
`default_nettype none
module port1_dma_write_comm_io_tb;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic flag = 1'b0;
	logic [31:0] burst_addr = 32'h1234_5678;
	logic wr_valid = 1'b0;
	logic [31:0] wr_data = 32'h0000_0000;
	logic comm_load = 1'b0;
	logic [31:0] comm_load_data = 32'h0000_0000;
	logic sel_n, target_ready_n_n, csel, rd, initiator_ready_n_n, end_n, qreq_n, oe, wr_ready, comm_written;
	logic [31:0] bus_lvl, bus_out, comm_reg;
	int n_fail = 0;
	int tests_run = 0;
	// ====================================================
	// Clock
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	// ====================================================
	// Device and partner
	port1_dma_write_comm_io i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_select_n_in(sel_n),
		.target_ready_pin_n_in(target_ready_n_n), .comm_port_select_in(csel), .port_read_dir_in(rd),
		.initiator_ready_n_out(initiator_ready_n_n), .end_of_burst_n_out(end_n), .queue_request_n_out(qreq_n),
		.port_addr_data_bus_in(bus_lvl), .port_addr_data_bus_out(bus_out), .port_addr_data_bus_oe_out(oe),
		.last_transfer_flag_in(flag), .burst_addr_in(burst_addr), .wr_valid_in(wr_valid),
		.wr_data_in(wr_data), .wr_ready_out(wr_ready), .comm_load_in(comm_load),
		.comm_load_data_in(comm_load_data), .comm_reg_out(comm_reg), .comm_written_out(comm_written));
	port1_arbiter_model i_arb (.clk_in(clk_in), .bus_from_dev_in(bus_out), .bus_oe_in(oe),
		.addr_select_n_out(sel_n), .target_ready_n_out(target_ready_n_n), .comm_port_select_out(csel),
		.port_read_dir_out(rd), .bus_level_out(bus_lvl));
	// ====================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : settle
	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	// ====================================================
	// Scenarios
	task automatic t_reset();
		settle(1);
		chk("oe", 32'h0, oe);
		chk("initiator_ready_n_n", 32'h1, initiator_ready_n_n);
		chk("end_n", 32'h1, end_n);
		chk("qreq_n", 32'h1, qreq_n);
		chk("comm_reg", 32'h0, comm_reg);
	endtask : t_reset
	task automatic t_fill();
		logic [31:0] w [3];
		w = '{32'ha1a1_0001, 32'hb2b2_0002, 32'hc3c3_0003};
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_in);
			wr_valid <= 1'b1;
			wr_data <= w[k];
			for (int i = 0; i < 8 && wr_ready !== 1'b1; i++) @(posedge clk_in);
		end
		@(posedge clk_in);
		wr_valid <= 1'b0;
		settle(2);
		chk("wr_ready full", 32'h0, wr_ready);
		chk("qreq_n", 32'h0, qreq_n);
	endtask : t_fill
	task automatic t_burst();
		i_arb.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
		settle(4);
		chk("addr oe", 32'h1, oe);
		chk("addr bus", burst_addr, bus_out);
		chk("addr initiator_ready_n_n", 32'h1, initiator_ready_n_n);
		chk("addr end_n", 32'h1, end_n);
		i_arb.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			settle(1);
			if (initiator_ready_n_n === 1'b0) break;
		end
		chk("write initiator_ready_n_n", 32'h0, initiator_ready_n_n);
		chk("write data", 32'ha1a1_0001, bus_out);
		settle(2);
		chk("write repeat", 32'h0, initiator_ready_n_n);
		i_arb.set_pins(1'b1, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			settle(1);
			if (initiator_ready_n_n === 1'b1) break;
		end
		chk("wait initiator_ready_n_n", 32'h1, initiator_ready_n_n);
		chk("wait oe", 32'h1, oe);
		i_arb.set_pins(1'b1, 1'b0, 1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			settle(1);
			if (initiator_ready_n_n === 1'b0) break;
		end
		chk("resume initiator_ready_n_n", 32'h0, initiator_ready_n_n);
		chk("resume end_n", 32'h1, end_n);
		@(posedge clk_in);
		flag <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			settle(1);
			if (end_n === 1'b0) break;
		end
		chk("last end_n", 32'h0, end_n);
		chk("last initiator_ready_n_n", 32'h0, initiator_ready_n_n);
		settle(1);
		chk("clean end_n", 32'h1, end_n);
		chk("clean initiator_ready_n_n", 32'h1, initiator_ready_n_n);
		settle(4);
		chk("idle oe", 32'h0, oe);
		chk("drained qreq_n", 32'h1, qreq_n);
		i_arb.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		settle(4);
		chk("tri oe", 32'h0, oe);
		@(posedge clk_in);
		flag <= 1'b0;
	endtask : t_burst
	task automatic t_comm_in();
		i_arb.drive_bus(1'b1, 32'h5a5a_c3c3);
		i_arb.set_pins(1'b0, 1'b1, 1'b1, 1'b0);
		settle(4);
		chk("cin oe", 32'h0, oe);
		chk("cin hold", 32'h0, comm_written);
		i_arb.set_pins(1'b0, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 10; i++) begin
			settle(1);
			if (comm_written === 1'b1) break;
		end
		chk("cin strobe", 32'h1, comm_written);
		chk("cin high", 32'h5a5a, comm_reg[31:16]);
		chk("cin low", 32'hc3c3, comm_reg[15:0]);
		settle(1);
		chk("cin pulse", 32'h0, comm_written);
		i_arb.drive_bus(1'b0, 32'h0000_0000);
	endtask : t_comm_in
	task automatic t_comm_out();
		int n;
		@(posedge clk_in);
		comm_load <= 1'b1;
		comm_load_data <= 32'h0f1e_2d3c;
		@(posedge clk_in);
		comm_load <= 1'b0;
		settle(1);
		chk("load", 32'h0f1e_2d3c, comm_reg);
		i_arb.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
		n = 0;
		for (int i = 0; i < 12; i++) begin
			settle(1);
			n++;
			if (oe === 1'b1) break;
		end
		chk("cout delay", 32'h5, 32'(n));
		chk("cout data", 32'h0f1e_2d3c, bus_out);
		settle(3);
		chk("cout repeat", 32'h1, oe);
		i_arb.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
		settle(4);
		chk("cout release", 32'h0, oe);
	endtask : t_comm_out
	// ====================================================
	// Sequence and watchdog
	initial begin
		repeat (2) @(posedge clk_in);
		reset_n_in <= 1'b1;
		t_reset();
		t_fill();
		t_burst();
		t_comm_in();
		t_comm_out();
		report_and_stop();
	end
	initial begin
		#(40 * 3000);
		n_fail++;
		$display("Watchdog expired");
		report_and_stop();
	end
endmodule : port1_dma_write_comm_io_tb
`default_nettype wire
